// >>> tpm_dev.sv
`timescale 1ns/1ps
// Operation
// R1: reset leaves the controller in full power
// R2: idle command moves full power to idle
// R3: attention line released while idle
// R4: host falling edge on attention wakes idle
// R5: host idle frame carries interval byte
// R6: idle mode scans once per interval
// R7: interval is byte times quarter millisecond
// R8: touch seen in idle scan wakes controller
// R9: sleep command makes controller deaf until woken
// R10: only host edge wakes from sleep
// R11: host sleep frame layout is fixed
// R12: waking queues notification and pulls attention low
// R13: host model query frame layout is fixed
// R14: query answered when attention low, host reads
// R15: model answer carries name and product identifier
// R16: slave answers at seven-bit address 2a
// R17: host write tagged, length 66, padded payload
// R18: host reads 66 bytes per response
// R19: attention low while unread data remains
// R20: attention synchronised and filtered before edge detect
// R21: unknown commands dropped, mode kept
module tpm_dev #(
  // model text and product identifier values are arbitrary
  parameter logic [0:5][7:0] MODEL_STR          = {8'h4d, 8'h44, 8'h4c, 8'h2d, 8'h41, 8'h42},
  parameter logic [0:3][7:0] PRODUCT_IDENTIFIER = {8'h30, 8'h42, 8'h32, 8'h43}
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic          ce,
  input  wire logic          touchSense,
  tpm_link_if.dev            link,
  output tpm_pkg::tpm_mode_e powerMode,
  output logic               scanPulse
);
  import tpm_pkg::*;

  typedef struct packed {
    tpm_mode_e                 mode;
    logic [2:0]                syn;
    logic                      filt;
    logic                      inFrm;
    logic                      own;
    logic                      hdrOk;
    logic [6:0]                cnt;
    logic [0:CMD_LEN-1][7:0]   pl;
    logic [7:0]                idleT;
    logic [11:0]               unitCnt;
    logic [7:0]                intCnt;
    logic                      scanPulse;
    tpm_resp_e                 pend;
    logic                      txOn;
    tpm_resp_e                 txKind;
    logic [6:0]                txIdx;
    logic                      attnOeN;
  } tpm_dev_s;

  localparam tpm_dev_s DEV_RESET = '{mode: TPM_FULL, syn: 3'h7, filt: 1'b1, inFrm: 1'b0,
    own: 1'b0, hdrOk: 1'b0, cnt: 7'h00, pl: '0, idleT: IDLE_T_RESET, unitCnt: 12'h000,
    intCnt: 8'h00, scanPulse: 1'b0, pend: RESP_NONE, txOn: 1'b0, txKind: RESP_NONE,
    txIdx: 7'h00, attnOeN: 1'b1};

  tpm_dev_s   s;
  tpm_dev_s   n;
  logic       fallEdge;
  logic       txReady;
  logic [7:0] txData;
  logic       addrHit;

  // compare captured payload bytes against a command pattern
  function automatic logic cmdHit(
    input logic [0:CMD_LEN-1][7:0] got,
    input logic [0:CMD_LEN-1][7:0] want,
    input int                      len
  );
    logic hit;
    hit = 1'b1;
    for (int i = 0; i < CMD_LEN; i++)
    begin
      if (i < len && got[i] != want[i])
        hit = 1'b0;
    end
    return hit;
  endfunction : cmdHit

  // byte idx of a 66-byte read: two length bytes, then the payload
  function automatic logic [7:0] respByte(
    input tpm_resp_e  k,
    input logic [6:0] idx
  );
    int         p;
    logic [7:0] b;
    p = int'(idx) - LEN_FIELD_N;
    b = 8'h00;
    if (idx == TAG0_POS)
      b = (k == RESP_MODEL) ? MODEL_LEN : (k == RESP_WAKE) ? WAKE_LEN : NONE_LEN;
    else if (p >= 0 && k == RESP_WAKE && p < WAKE_N)
      b = WAKE_MSG[p]; // R12
    else if (p >= 0 && k == RESP_MODEL)
    begin
      if (p < MODEL_HDR_N)
        b = MODEL_HDR[p]; // R15
      else if (p < PID_POS)
        b = MODEL_STR[p - MODEL_HDR_N]; // R15
      else if (p < PID_POS + PID_N)
        b = PRODUCT_IDENTIFIER[p - PID_POS]; // R15
    end
    return b;
  endfunction : respByte

  always_comb
  begin
    n = s;
    n.scanPulse = 1'b0;
    addrHit = 1'b0;
    txData = respByte(s.txKind, s.txIdx);

    // three-stage sampler; a level counts once the last two stages agree
    n.syn = {s.syn[1:0], link.attnLevel};
    fallEdge = s.filt && (s.syn[1] == s.syn[2]) && !s.syn[2]; // R20
    if (s.syn[1] == s.syn[2])
      n.filt = s.syn[2]; // R20

    // receive side: first byte of a frame is the address byte
    if (link.wrValid)
    begin
      if (!s.inFrm)
      begin
        addrHit = (link.wrByte[7:1] == DEV_ADDR); // R16
        n.inFrm = !link.wrLast;
        n.own   = addrHit && (link.wrByte[0] == RW_WRITE) && (s.mode != TPM_SLEEP); // R9
        n.hdrOk = 1'b1;
        n.cnt   = '0;
        // read request: only answered in full power, one at a time
        if (addrHit && link.wrByte[0] == RW_READ && link.wrLast && s.mode == TPM_FULL
            && !s.txOn)
        begin
          n.txOn   = 1'b1; // R14
          n.txKind = s.pend;
          n.pend   = RESP_NONE;
          n.txIdx  = '0;
        end
      end
      else
      begin
        n.inFrm = !link.wrLast;
        n.cnt   = s.cnt + 7'h01;
        if ((s.cnt == TAG0_POS && link.wrByte != WR_TAG0)
            || (s.cnt == TAG1_POS && link.wrByte != WR_TAG1))
          n.hdrOk = 1'b0;
        if (s.cnt >= PAYLOAD_BASE && s.cnt < PAYLOAD_END)
          n.pl[3'(s.cnt - PAYLOAD_BASE)] = link.wrByte;
        // decode at end of frame; short or foreign frames are ignored
        if (link.wrLast && s.own && n.hdrOk && s.cnt >= MIN_LAST_POS)
        begin
          if (cmdHit(n.pl, QUERY_CMD, QUERY_N))
            n.pend = RESP_MODEL; // R14
          else if (cmdHit(n.pl, IDLE_CMD, IDLE_N))
          begin
            n.mode  = TPM_IDLE; // R2
            n.idleT = n.pl[IDLE_T_POS]; // R7
          end
          else if (cmdHit(n.pl, SLEEP_CMD, SLEEP_N))
            n.mode = TPM_SLEEP; // R9
          // any other opcode changes nothing R21
        end
      end
    end

    // idle scan timer: quarter-millisecond units, idleT units per scan
    if (s.mode == TPM_IDLE)
    begin
      n.unitCnt = s.unitCnt + 12'h001;
      if (s.unitCnt == SCAN_UNIT_MAX)
      begin
        n.unitCnt = '0; // R7
        n.intCnt  = s.intCnt + 8'h01;
        // an interval byte of zero behaves as one unit
        if (n.intCnt >= s.idleT)
        begin
          n.intCnt    = '0;
          n.scanPulse = 1'b1; // R6
          if (touchSense)
          begin
            n.mode = TPM_FULL; // R8
            n.pend = RESP_WAKE; // R12
          end
        end
      end
    end

    // host wake edge; sleep ignores touch, so only this path leaves it
    if (fallEdge && s.mode != TPM_FULL)
    begin
      n.mode = TPM_FULL; // R4 R10
      n.pend = RESP_WAKE; // R12
    end
    if (n.mode != TPM_IDLE)
    begin
      n.unitCnt = '0;
      n.intCnt  = '0;
    end

    // feed the response into the buffer; stalls when the host stops reading
    if (s.txOn && txReady)
    begin
      n.txIdx = s.txIdx + 7'h01;
      if (s.txIdx == READ_LAST)
      begin
        n.txOn  = 1'b0;
        n.txIdx = '0;
      end
    end

    // attention only in full power, held until the last byte left the buffer
    n.attnOeN = !((n.mode == TPM_FULL)
                  && (n.pend != RESP_NONE || n.txOn || link.rdValid)); // R3 R12 R19
  end

  // R1
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s <= DEV_RESET;
    else if (ce)
      s <= n;
  end

  tpm_buf u_buf (
    .clk      (clk),
    .resetn   (resetn),
    .ce       (ce),
    .inValid  (s.txOn),
    .inData   (txData),
    .inReady  (txReady),
    .outValid (link.rdValid),
    .outData  (link.rdByte),
    .outReady (link.rdReady)
  );

  assign powerMode       = s.mode;
  assign scanPulse       = s.scanPulse;
  assign link.devAttnOeN = s.attnOeN;
  assign link.devAttnOut = 1'b0;
endmodule : tpm_dev

// >>> tpm_pkg.sv
package tpm_pkg;
  // link addressing and framing
  localparam logic [6:0] DEV_ADDR      = 7'h2a;
  localparam logic       RW_WRITE      = 1'b0;
  localparam logic       RW_READ       = 1'b1;
  localparam logic [7:0] WR_TAG0       = 8'h67;
  localparam logic [7:0] WR_TAG1       = 8'h00;
  localparam logic [7:0] FRAME_LEN     = 8'h42;
  localparam logic [6:0] TAG0_POS      = 7'h00;
  localparam logic [6:0] TAG1_POS      = 7'h01;
  localparam logic [6:0] LEN_LSB_POS   = 7'h02;
  localparam logic [6:0] PAYLOAD_BASE  = 7'h04;
  localparam logic [6:0] PAYLOAD_END   = 7'h0c;
  localparam logic [6:0] MIN_LAST_POS  = 7'h0b;
  localparam logic [6:0] FRAME_LAST    = 7'h43;
  localparam logic [6:0] READ_LAST     = 7'h41;
  localparam int         LEN_FIELD_N   = 2;

  // command packets, zero padded to the captured width
  localparam int CMD_LEN     = 8;
  localparam int QUERY_N     = 8;
  localparam int IDLE_N      = 7;
  localparam int SLEEP_N     = 8;
  localparam int IDLE_T_POS  = 7;
  localparam logic [0:CMD_LEN-1][7:0] QUERY_CMD =
    {8'h42, 8'h00, 8'h03, 8'h01, 8'h45, 8'h00, 8'h00, 8'h00};
  localparam logic [0:CMD_LEN-1][7:0] IDLE_CMD =
    {8'h42, 8'h00, 8'h03, 8'h04, 8'h36, 8'h3f, 8'h01, 8'h00};
  localparam logic [0:CMD_LEN-1][7:0] SLEEP_CMD =
    {8'h42, 8'h00, 8'h03, 8'h03, 8'h36, 8'h3f, 8'h02, 8'h00};

  // responses
  localparam int         WAKE_N        = 7;
  localparam int         MODEL_HDR_N   = 5;
  localparam int         MODEL_STR_N   = 6;
  localparam int         PID_POS       = 11;
  localparam int         PID_N         = 4;
  localparam logic [0:WAKE_N-1][7:0] WAKE_MSG =
    {8'h42, 8'h00, 8'h03, 8'h03, 8'h36, 8'h3f, 8'h01};
  localparam logic [0:MODEL_HDR_N-1][7:0] MODEL_HDR =
    {8'h42, 8'h00, 8'h03, 8'h0c, 8'h45};
  localparam logic [7:0] NONE_LEN      = 8'h02;
  localparam logic [7:0] WAKE_LEN      = 8'h09;
  localparam logic [7:0] MODEL_LEN     = 8'h12;

  // timing at a 100 ns clock
  localparam int          CLK_NS        = 100;
  localparam int          SCAN_UNIT_NS  = 250000;
  localparam int          SCAN_UNIT_CYC = SCAN_UNIT_NS / CLK_NS;
  localparam logic [11:0] SCAN_UNIT_MAX = 12'(SCAN_UNIT_CYC - 1);
  localparam logic [7:0]  IDLE_T_RESET  = 8'h1e;
  localparam logic [6:0]  WAKE_LOW_LAST = 7'h03;
  localparam logic [6:0]  GAP_LAST      = 7'h05;

  // response buffer shape
  localparam int BYTE_W    = 8;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {TPM_FULL, TPM_IDLE, TPM_SLEEP} tpm_mode_e;
  typedef enum logic [1:0] {RESP_NONE, RESP_MODEL, RESP_WAKE} tpm_resp_e;
  typedef enum logic [1:0] {CMD_QUERY, CMD_IDLE, CMD_SLEEP, CMD_WAKE} tpm_cmd_e;
endpackage : tpm_pkg

// >>> tpm_link_if.sv
`timescale 1ns/1ps
interface tpm_link_if;
  logic       wrValid;
  logic [7:0] wrByte;
  logic       wrLast;
  logic       rdValid;
  logic [7:0] rdByte;
  logic       rdReady;
  logic       devAttnOut;
  logic       devAttnOeN;
  logic       hostAttnOut;
  logic       hostAttnOeN;
  logic       attnLevel;

  // attention wire with pull-up; either end may pull it low
  assign attnLevel = !((!devAttnOeN && !devAttnOut) || (!hostAttnOeN && !hostAttnOut));

  modport dev (
    input  wrValid, wrByte, wrLast, rdReady, attnLevel,
    output rdValid, rdByte, devAttnOut, devAttnOeN
  );
  modport host (
    input  rdValid, rdByte, attnLevel,
    output wrValid, wrByte, wrLast, rdReady, hostAttnOut, hostAttnOeN
  );
endinterface : tpm_link_if

// >>> tpm_buf.sv
`timescale 1ns/1ps
module tpm_buf #(
  parameter int DW    = tpm_pkg::BYTE_W,
  parameter int DEPTH = tpm_pkg::BUF_DEPTH
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic          ce,
  input  wire logic          inValid,
  input  wire logic [DW-1:0] inData,
  output logic               inReady,
  output logic               outValid,
  output logic [DW-1:0]      outData,
  input  wire logic          outReady
);
  import tpm_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0]         vld;
    logic [DEPTH-1:0][DW-1:0] dat;
  } tpm_buf_s;

  tpm_buf_s s;
  tpm_buf_s n;
  logic     placed;

  // shift buffer: entry 0 is always the head, so the output is a plain flop
  always_comb
  begin
    n = s;
    placed = 1'b0;
    if (outReady && s.vld[0])
    begin
      n.vld = s.vld >> 1;
      n.dat = s.dat >> DW;
    end
    // full is judged before the pop, trading a cycle of throughput for no comb path
    if (inValid && !s.vld[DEPTH-1])
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (!placed && !n.vld[i])
        begin
          n.vld[i] = 1'b1;
          n.dat[i] = inData;
          placed = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s <= '0;
    else if (ce)
      s <= n;
  end

  assign inReady  = !s.vld[DEPTH-1];
  assign outValid = s.vld[0];
  assign outData  = s.dat[0];
endmodule : tpm_buf

// >>> tpm_host.sv
`timescale 1ns/1ps
module tpm_host (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic         cmdValid,
  input  tpm_pkg::tpm_cmd_e cmdKind,
  input  wire logic [7:0]   cmdArg,
  output logic              cmdReady,
  output logic              respValid,
  output logic [7:0]        respByte,
  output logic              respLast,
  input  wire logic         respReady,
  tpm_link_if.host          link
);
  import tpm_pkg::*;

  typedef enum logic [2:0] {H_READY, H_WR, H_RD, H_WAKE, H_GAP} tpm_hstate_e;

  typedef struct packed {
    tpm_hstate_e st;
    tpm_cmd_e    kind;
    logic [7:0]  arg;
    logic [6:0]  cnt;
    logic        wrValid;
    logic [7:0]  wrByte;
    logic        wrLast;
    logic        rdReady;
    logic        respValid;
    logic [7:0]  respByte;
    logic        respLast;
    logic        attnOeN;
    logic        cmdReady;
  } tpm_host_s;

  localparam tpm_host_s HOST_RESET = '{st: H_READY, kind: CMD_QUERY, arg: 8'h00, cnt: 7'h00,
    wrValid: 1'b0, wrByte: 8'h00, wrLast: 1'b0, rdReady: 1'b0, respValid: 1'b0,
    respByte: 8'h00, respLast: 1'b0, attnOeN: 1'b1, cmdReady: 1'b1};

  tpm_host_s s;
  tpm_host_s n;

  // frame byte i after the address: tag, length 66, zero-padded payload
  function automatic logic [7:0] hostByte(
    input tpm_cmd_e   k,
    input logic [7:0] arg,
    input logic [6:0] i
  );
    int         p;
    logic [7:0] b;
    p = int'(i) - int'(PAYLOAD_BASE);
    b = 8'h00;
    if (i == TAG0_POS)
      b = WR_TAG0; // R17
    else if (i == TAG1_POS)
      b = WR_TAG1; // R17
    else if (i == LEN_LSB_POS)
      b = FRAME_LEN; // R17
    else if (p >= 0 && p < CMD_LEN)
    begin
      case (k)
        CMD_QUERY: b = QUERY_CMD[p]; // R13
        CMD_IDLE:  b = (p == IDLE_T_POS) ? arg : IDLE_CMD[p]; // R5
        CMD_SLEEP: b = SLEEP_CMD[p]; // R11
        default:   b = 8'h00;
      endcase
    end
    return b;
  endfunction : hostByte

  always_comb
  begin
    n = s;
    n.wrValid = 1'b0;
    n.wrLast  = 1'b0;
    if (s.respValid && respReady)
      n.respValid = 1'b0;
    case (s.st)
      H_READY:
      begin
        // a command comes first; a pending attention waits for it
        if (cmdValid && s.cmdReady)
        begin
          n.kind = cmdKind;
          n.arg  = cmdArg;
          n.cnt  = '0;
          if (cmdKind == CMD_WAKE)
          begin
            n.st      = H_WAKE;
            n.attnOeN = 1'b0; // R4 R10
          end
          else
          begin
            n.st      = H_WR;
            n.wrValid = 1'b1;
            n.wrByte  = {DEV_ADDR, RW_WRITE}; // R16
          end
        end
        else if (!link.attnLevel)
        begin
          n.st      = H_RD; // R14
          n.cnt     = '0;
          n.wrValid = 1'b1;
          n.wrByte  = {DEV_ADDR, RW_READ}; // R16
          n.wrLast  = 1'b1;
        end
      end
      H_WR:
      begin
        n.wrValid = 1'b1;
        n.wrByte  = hostByte(s.kind, s.arg, s.cnt);
        n.wrLast  = (s.cnt == FRAME_LAST); // R17
        n.cnt     = s.cnt + 7'h01;
        if (s.cnt == FRAME_LAST)
        begin
          n.st  = H_GAP;
          n.cnt = '0;
        end
      end
      H_RD:
      begin
        if (link.rdValid && s.rdReady)
        begin
          n.respValid = 1'b1;
          n.respByte  = link.rdByte;
          n.respLast  = (s.cnt == READ_LAST); // R18
          n.cnt       = s.cnt + 7'h01;
          if (s.cnt == READ_LAST)
          begin
            n.st  = H_GAP;
            n.cnt = '0;
          end
        end
      end
      H_WAKE:
      begin
        // hold long enough for the far end's agreement filter to see it
        n.cnt = s.cnt + 7'h01;
        if (s.cnt == WAKE_LOW_LAST)
        begin
          n.attnOeN = 1'b1;
          n.st      = H_GAP;
          n.cnt     = '0;
        end
      end
      H_GAP:
      begin
        // lets the attention line settle so one response is not read twice
        n.cnt = s.cnt + 7'h01;
        if (s.cnt == GAP_LAST)
          n.st = H_READY;
      end
      default: n.st = H_READY;
    endcase
    n.rdReady  = (n.st == H_RD) && !n.respValid;
    n.cmdReady = (n.st == H_READY);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s <= HOST_RESET;
    else if (ce)
      s <= n;
  end

  assign cmdReady         = s.cmdReady;
  assign respValid        = s.respValid;
  assign respByte         = s.respByte;
  assign respLast         = s.respLast;
  assign link.wrValid     = s.wrValid;
  assign link.wrByte      = s.wrByte;
  assign link.wrLast      = s.wrLast;
  assign link.rdReady     = s.rdReady;
  assign link.hostAttnOeN = s.attnOeN;
  assign link.hostAttnOut = 1'b0;
endmodule : tpm_host

// >>> tpm_link_assertions.sv
`timescale 1ns/1ps
module tpm_link_assertions
  import tpm_pkg::*;
(
  input wire logic          clk,
  input wire logic          resetn,
  input tpm_pkg::tpm_mode_e powerMode,
  input wire logic          wrValid,
  input wire logic [7:0]    wrByte,
  input wire logic          wrLast,
  input wire logic          rdValid,
  input wire logic [7:0]    rdByte,
  input wire logic          rdReady,
  input wire logic          devAttnOeN,
  input wire logic          hostAttnOeN,
  input wire logic          attnLevel
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // cycles since the host last pulled the wire; only a recent host pull may end sleep
  logic [3:0] hostLowAge;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      hostLowAge <= 4'hf;
    else if (!hostAttnOeN)
      hostLowAge <= 4'h0;
    else if (hostLowAge != 4'hf)
      hostLowAge <= hostLowAge + 4'h1;
  end

  // reset must hold full power even without a clock edge of its own
  a_reset_full_power: assert property (disable iff (1'b0) !resetn |-> powerMode == TPM_FULL)
    else $error("mode not full power in reset");
  a_low_mode_cause: assert property ($past(powerMode) == TPM_FULL && powerMode != TPM_FULL
    |-> $past(wrValid && wrLast))
    else $error("low power mode entered without a frame end");
  a_attn_released_low: assert property (powerMode != TPM_FULL && $past(powerMode) != TPM_FULL
    |-> devAttnOeN)
    else $error("device drives attention while in low power");
  a_host_edge_wakes: assert property ($fell(attnLevel) && !hostAttnOeN && powerMode != TPM_FULL
    |-> ##[1:8] powerMode == TPM_FULL)
    else $error("host edge did not wake the device");
  a_wake_notify_attn: assert property ($rose(powerMode == TPM_FULL) |-> ##[1:2] !devAttnOeN)
    else $error("no attention after wake");
  a_sleep_is_deaf: assert property (powerMode == TPM_SLEEP |-> !rdValid)
    else $error("read data offered while asleep");
  a_sleep_host_only: assert property ($past(powerMode) == TPM_SLEEP && powerMode == TPM_FULL
    |-> hostLowAge < 4'h8)
    else $error("sleep ended without host edge");
  a_attn_unread_data: assert property (rdValid |-> !devAttnOeN)
    else $error("attention released with unread data");
  a_read_byte_hold: assert property (rdValid && !rdReady |=> rdValid && $stable(rdByte))
    else $error("read byte dropped before taken");
  a_read_answer_time: assert property (wrValid && wrLast && wrByte == {DEV_ADDR, RW_READ}
    && powerMode == TPM_FULL && !devAttnOeN |-> ##2 rdValid)
    else $error("read not answered in two cycles");
endmodule : tpm_link_assertions

// >>> touch_power_mode_commands_tb.sv
`timescale 1ns/1ps
`define CHK(g, e, m) begin numChecks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t %s got %h want %h", $time, m, g, e); end end
module touch_power_mode_commands_tb;
  import tpm_pkg::*;
  // model text and product identifier: arbitrary values
  localparam logic [0:5][7:0] MS = {8'h51, 8'h52, 8'h2d, 8'h37, 8'h31, 8'h30};
  localparam logic [0:3][7:0] PI = {8'h37, 8'h43, 8'h35, 8'h45};
  logic       clk;
  logic       resetn;
  logic       ce;
  logic       touchSense;
  logic       cmdValid;
  tpm_cmd_e   cmdKind;
  logic [7:0] cmdArg;
  logic       cmdReady;
  logic       respValid;
  logic [7:0] respByte;
  logic       respLast;
  logic       respReady;
  tpm_mode_e  powerMode;
  tpm_mode_e  powerMode2;
  logic       scanPulse;
  logic [7:0] rnd;
  int         fails;
  int         numChecks;
  int         gap;

  tpm_link_if link ();
  tpm_link_if link2 ();
  tpm_dev #(.MODEL_STR(MS), .PRODUCT_IDENTIFIER(PI)) i_tpm_dev (.clk(clk), .resetn(resetn),
    .ce(ce), .touchSense(touchSense), .link(link.dev), .powerMode(powerMode),
    .scanPulse(scanPulse));
  tpm_host i_tpm_host (.clk(clk), .resetn(resetn), .ce(ce), .cmdValid(cmdValid),
    .cmdKind(cmdKind), .cmdArg(cmdArg), .cmdReady(cmdReady), .respValid(respValid),
    .respByte(respByte), .respLast(respLast), .respReady(respReady), .link(link.host));
  // second device faces a hand-driven host that sends malformed frames
  tpm_dev i_tpm_dev_2 (.clk(clk), .resetn(resetn), .ce(ce), .touchSense(1'b0),
    .link(link2.dev), .powerMode(powerMode2), .scanPulse());
  tpm_link_assertions i_tpm_link_assertions (.clk(clk), .resetn(resetn),
    .powerMode(powerMode), .wrValid(link.wrValid), .wrByte(link.wrByte), .wrLast(link.wrLast),
    .rdValid(link.rdValid), .rdByte(link.rdByte), .rdReady(link.rdReady),
    .devAttnOeN(link.devAttnOeN), .hostAttnOeN(link.hostAttnOeN), .attnLevel(link.attnLevel));

  // 100 ns clock
  always #50 clk = ~clk;

  function automatic logic [7:0] lfsrNext(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsrNext

  // expected 66-byte stream: two length bytes, then the payload
  function automatic logic [7:0] expByte(input tpm_resp_e k, input int i);
    logic [0:6][7:0] wk;
    logic [0:4][7:0] hd;
    int              p;
    wk = {8'h42, 8'h00, 8'h03, 8'h03, 8'h36, 8'h3f, 8'h01};
    hd = {8'h42, 8'h00, 8'h03, 8'h0c, 8'h45};
    p = i - 2;
    if (i == 1)
      return 8'h00;
    if (k == RESP_MODEL)
    begin
      if (i == 0) return 8'h12;
      if (p < 5) return hd[p];
      if (p < 11) return MS[p - 5];
      if (p < 15) return PI[p - 11];
    end
    else if (k == RESP_WAKE)
    begin
      if (i == 0) return 8'h09;
      if (p < 7) return wk[p];
    end
    else if (i == 0)
      return 8'h02;
    return 8'h00;
  endfunction : expByte

  task automatic conclude;
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic waitFail(input string m);
    fails++;
    $display("[FAIL] t=%0t wait ran out: %s", $time, m);
    conclude();
  endtask : waitFail

  task automatic tick;
    @(posedge clk);
    #10;
  endtask : tick

  task automatic send(input tpm_cmd_e k, input logic [7:0] a);
    int t;
    t = 0;
    while (cmdReady !== 1'b1 && t < 500)
    begin
      tick();
      t++;
    end
    if (t == 500) waitFail("command port");
    cmdKind = k;
    cmdArg = a;
    cmdValid = 1'b1;
    tick();
    cmdValid = 1'b0;
  endtask : send

  task automatic waitMode(input tpm_mode_e m, input int bound);
    int t;
    t = 0;
    while (powerMode !== m && t < bound)
    begin
      tick();
      t++;
    end
    if (powerMode !== m) waitFail("mode change");
  endtask : waitMode

  // take one 66-byte response; the random ready stalls the host mid-stream
  task automatic collect(input tpm_resp_e k);
    int n;
    int t;
    n = 0;
    t = 0;
    while (n < 66 && t < 3000)
    begin
      @(negedge clk);
      if (respValid === 1'b1 && respReady === 1'b1)
      begin
        `CHK(respByte, expByte(k, n), "response byte")
        if (n == 65) `CHK(respLast, 1'b1, "last byte flag")
        n++;
      end
      tick();
      rnd = lfsrNext(rnd);
      respReady = rnd[0] | rnd[1];
      t++;
    end
    if (n < 66) waitFail("response stream");
  endtask : collect

  task automatic scanGap(output int g);
    int t;
    t = 0;
    while (scanPulse !== 1'b1 && t < 12000)
    begin
      @(negedge clk);
      t++;
    end
    if (t == 12000) waitFail("scan");
    t = 0;
    @(negedge clk);
    while (scanPulse !== 1'b1 && t < 12000)
    begin
      @(negedge clk);
      t++;
    end
    if (t == 12000) waitFail("scan");
    g = t + 1;
  endtask : scanGap

  // tagged frame of 68 bytes after the address byte, length 66, payload zero padded
  task automatic rawFrame(input logic [6:0] a, input logic [0:7][7:0] pl);
    logic [7:0] b;
    for (int i = 0; i < 69; i++)
    begin
      case (i)
        0: b = {a, RW_WRITE};
        1: b = 8'h67;
        3: b = 8'h42;
        2, 4: b = 8'h00;
        default: b = (i < 13) ? pl[i - 5] : 8'h00;
      endcase
      link2.wrValid = 1'b1;
      link2.wrByte = b;
      link2.wrLast = (i == 68);
      tick();
    end
    link2.wrValid = 1'b0;
    link2.wrLast = 1'b0;
    repeat (3) tick();
  endtask : rawFrame

  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    ce = 1'b1;
    touchSense = 1'b0;
    cmdValid = 1'b0;
    cmdKind = CMD_QUERY;
    cmdArg = 8'h00;
    respReady = 1'b0;
    rnd = 8'h1a;
    fails = 0;
    numChecks = 0;
    {link2.wrValid, link2.wrLast, link2.rdReady, link2.hostAttnOut} = 4'h0;
    link2.wrByte = 8'h00;
    link2.hostAttnOeN = 1'b1;
    repeat (6) @(posedge clk);
    #10;
    resetn = 1'b1;
    tick();
    `CHK(powerMode, TPM_FULL, "mode after reset")
    `CHK(link.attnLevel, 1'b1, "attention idle after reset")
    $display("test reset done");
    // model query answered on attention
    send(CMD_QUERY, 8'h00);
    collect(RESP_MODEL);
    $display("test query done");
    // idle at a random short interval, woken by touch
    rnd = lfsrNext(rnd);
    send(CMD_IDLE, {7'h00, rnd[0]} + 8'h01);
    waitMode(TPM_IDLE, 300);
    `CHK(powerMode, TPM_IDLE, "idle entered")
    `CHK(link.attnLevel, 1'b1, "attention released in idle")
    scanGap(gap);
    `CHK(gap, (rnd[0] + 1) * 2500, "idle scan spacing")
    touchSense = 1'b1;
    waitMode(TPM_FULL, 6000);
    `CHK(powerMode, TPM_FULL, "touch wakes idle")
    touchSense = 1'b0;
    collect(RESP_WAKE);
    $display("test idle touch done");
    // idle at the reset interval, woken by the host edge
    send(CMD_IDLE, 8'h1e);
    waitMode(TPM_IDLE, 300);
    send(CMD_WAKE, 8'h00);
    waitMode(TPM_FULL, 50);
    `CHK(powerMode, TPM_FULL, "host edge wakes idle")
    collect(RESP_WAKE);
    $display("test idle host wake done");
    // sleep ignores touch and queries; only the host edge ends it
    touchSense = 1'b1;
    send(CMD_SLEEP, 8'h00);
    waitMode(TPM_SLEEP, 300);
    repeat (3000) tick();
    `CHK(powerMode, TPM_SLEEP, "touch ignored asleep")
    send(CMD_QUERY, 8'h00);
    repeat (100) tick();
    `CHK(respValid, 1'b0, "no answer asleep")
    `CHK(link.attnLevel, 1'b1, "attention released asleep")
    touchSense = 1'b0;
    send(CMD_WAKE, 8'h00);
    waitMode(TPM_FULL, 50);
    `CHK(powerMode, TPM_FULL, "host edge wakes sleep")
    collect(RESP_WAKE);
    $display("test sleep done");
    // malformed frames leave the second device in full power
    rawFrame(7'h2b, {8'h42, 8'h00, 8'h03, 8'h04, 8'h36, 8'h3f, 8'h01, 8'h01});
    `CHK(powerMode2, TPM_FULL, "foreign address ignored")
    rawFrame(DEV_ADDR, {8'h42, 8'h00, 8'h03, 8'h04, 8'h36, 8'h3f, 8'h05, 8'h01});
    `CHK(powerMode2, TPM_FULL, "unknown opcode ignored")
    rawFrame(DEV_ADDR, {8'h42, 8'h00, 8'h03, 8'h04, 8'h36, 8'h3f, 8'h01, 8'h01});
    `CHK(powerMode2, TPM_IDLE, "well formed idle taken")
    `CHK(link2.attnLevel, 1'b1, "second link released")
    link2.hostAttnOeN = 1'b0;
    tick();
    link2.hostAttnOeN = 1'b1;
    repeat (4) tick();
    `CHK(powerMode2, TPM_IDLE, "glitch ignored")
    link2.hostAttnOeN = 1'b0;
    repeat (4) tick();
    link2.hostAttnOeN = 1'b1;
    tick();
    `CHK(powerMode2, TPM_FULL, "held pull wakes")
    $display("test raw frames done");
    conclude();
  end
endmodule : touch_power_mode_commands_tb
